// file: hdl/serdes_config_latch_bank.sv
// Design decision made here: the AXI4-Lite slave port.
module serdes_config_latch_bank
    import cfg_latch_pkg::*;
#(
    parameter int ADDR_W = 6
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tx_speed_range_sel,
    input wire logic tx_input_clock,
    output logic [4:0] tx_pll_mult_q,
    output logic tx_clock_double_q,
    output logic tx_capture_both_edges_q,
    output logic tx_input_clock_sel_q,
    output logic tx_selftest_en_q,
    output logic tx_primary_driver_en_q,
    output logic tx_secondary_driver_en_q,
    output logic tx_logic_power_en_q,
    output logic phase_buffer_recenter_q,
    output logic config_invalid_q
);

    // ****************************************
    // Elaboration checks and decode helpers
    // ****************************************
    generate
        if (ADDR_W < 6 || ADDR_W > 32)
        begin : g_chk
            $error("ADDR_W must lie between 6 and 32");
        end
    endgenerate

    function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] sh;
        sh = a >> 2;
        if (sh > ADDR_W'(STATUS_IDX))
            reg_index = 4'hf;
        else
            reg_index = sh[3:0];
    endfunction

    function automatic logic latch_writable(input logic [3:0] idx);
        latch_writable = (idx < 4'(LATCH_COUNT)) && (idx != INTERNAL_TEST_LOW_IDX)
            && (idx != INTERNAL_TEST_HIGH_IDX);
    endfunction

    function automatic logic [6:0] reset_pattern(input int idx);
        case (idx)
            0: reset_pattern = RX_CLOCK_RATE_CFG_RST;
            1: reset_pattern = RX_DETECT_TRAINING_CFG_RST;
            2: reset_pattern = RX_CHANNEL_CTRL_RST;
            5: reset_pattern = TX_STATIC_CFG_RST;
            6: reset_pattern = TX_CLOCKING_CFG_RST;
            7: reset_pattern = TX_CHANNEL_CTRL_RST;
            default: reset_pattern = INTERNAL_TEST_RST;
        endcase
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [1:0] pin_sync;
    logic tx_clk_s;
    logic speed_s;
    logic tx_clk_prev_q;
    logic tx_clk_rise;

    cfg_sync2 #(.WIDTH(2)) u_sync
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({tx_speed_range_sel, tx_input_clock}),
        .sync_out(pin_sync)
    );

    assign tx_clk_s = pin_sync[0];
    assign speed_s = pin_sync[1];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            tx_clk_prev_q <= 1'b0;
        else
            tx_clk_prev_q <= tx_clk_s;
    end

    // Edge of the transmit input clock as seen in aclk
    assign tx_clk_rise = tx_clk_s && !tx_clk_prev_q;

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    logic aw_have_q;
    logic w_have_q;
    logic [3:0] wr_idx_q;
    logic [6:0] wr_data_q;
    logic wr_lane_q;
    logic aw_take;
    logic w_take;
    logic b_done;
    logic wr_commit;
    logic wr_ok;

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign b_done = s_axi_bvalid && s_axi_bready;
    assign wr_commit = aw_have_q && w_have_q && !s_axi_bvalid;
    // Reserved test addresses and the status word refuse writes
    assign wr_ok = latch_writable(wr_idx_q);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            s_axi_awready <= 1'b0;
            wr_idx_q <= 4'h0;
        end
        else
        begin
            if (aw_take)
                wr_idx_q <= reg_index(s_axi_awaddr);
            aw_have_q <= aw_take || (aw_have_q && !b_done);
            s_axi_awready <= !(aw_take || (aw_have_q && !b_done));
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_have_q <= 1'b0;
            s_axi_wready <= 1'b0;
            wr_data_q <= 7'h00;
            wr_lane_q <= 1'b0;
        end
        else
        begin
            if (w_take)
            begin
                wr_data_q <= s_axi_wdata[6:0];
                wr_lane_q <= s_axi_wstrb[0];
            end
            w_have_q <= w_take || (w_have_q && !b_done);
            s_axi_wready <= !(w_take || (w_have_q && !b_done));
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (wr_commit)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (b_done)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************
    // Latch bank
    // ****************************************
    logic [6:0] latch_q [LATCH_COUNT];
    logic recenter_fire;
    logic latch_we;

    assign latch_we = wr_commit && wr_ok && wr_lane_q;
    assign recenter_fire = tx_clk_rise && !latch_q[7][PHASE_BUFFER_RECENTER_BIT];

    generate
        for (genvar i = 0; i < LATCH_COUNT; i++)
        begin : g_latch
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    latch_q[i] <= reset_pattern(i);
                else if (latch_we && wr_idx_q == 4'(i))
                    latch_q[i] <= wr_data_q;
                else if (i == 7 && recenter_fire)
                    latch_q[i][PHASE_BUFFER_RECENTER_BIT] <= 1'b1;
            end
        end
    endgenerate

    // ****************************************
    // Transmit channel controls
    // ****************************************
    logic rate_l;
    logic cksel_l;
    logic drv1_l;
    logic drv2_l;

    assign rate_l = latch_q[6][TX_PLL_RATE_SEL_BIT];
    assign cksel_l = latch_q[6][TX_INPUT_CLOCK_SEL_BIT];
    assign drv1_l = latch_q[7][TX_PRIMARY_DRIVER_EN_BIT];
    assign drv2_l = latch_q[7][TX_SECONDARY_DRIVER_EN_BIT];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_pll_mult_q <= PLL_MULT_FULL;
            tx_clock_double_q <= 1'b0;
            tx_capture_both_edges_q <= 1'b0;
            tx_input_clock_sel_q <= 1'b1;
        end
        else
        begin
            tx_pll_mult_q <= rate_l ? PLL_MULT_HALF : PLL_MULT_FULL;
            tx_clock_double_q <= rate_l;
            tx_capture_both_edges_q <= cksel_l && rate_l;
            tx_input_clock_sel_q <= cksel_l;
        end
    end

    // Drivers fall at the first aclk edge in reset, whatever the latches hold
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_primary_driver_en_q <= 1'b0;
            tx_secondary_driver_en_q <= 1'b0;
            tx_logic_power_en_q <= 1'b0;
            tx_selftest_en_q <= 1'b0;
        end
        else
        begin
            tx_primary_driver_en_q <= drv1_l;
            tx_secondary_driver_en_q <= drv2_l;
            tx_logic_power_en_q <= drv1_l || drv2_l;
            tx_selftest_en_q <= !latch_q[7][TX_SELFTEST_DISABLE_BIT];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            phase_buffer_recenter_q <= 1'b0;
            config_invalid_q <= 1'b0;
        end
        else
        begin
            phase_buffer_recenter_q <= recenter_fire;
            // Only flagged; the combination is the host's to avoid
            config_invalid_q <= rate_l && !speed_s;
        end
    end

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    logic ar_take;
    logic r_done;
    logic [3:0] rd_idx;
    logic [6:0] status_word;

    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign r_done = s_axi_rvalid && s_axi_rready;
    assign rd_idx = reg_index(s_axi_araddr);

    always_comb
    begin
        status_word = 7'h00;
        status_word[ST_PRIMARY_BIT] = tx_primary_driver_en_q;
        status_word[ST_SECONDARY_BIT] = tx_secondary_driver_en_q;
        status_word[ST_LOGIC_POWER_BIT] = tx_logic_power_en_q;
        status_word[ST_RECENTER_PEND_BIT] = !latch_q[7][PHASE_BUFFER_RECENTER_BIT];
        status_word[ST_INVALID_BIT] = config_invalid_q;
        status_word[ST_BOTH_EDGES_BIT] = tx_capture_both_edges_q;
        status_word[ST_SPEED_BIT] = speed_s;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !(ar_take || (s_axi_rvalid && !r_done));
            if (ar_take)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= (rd_idx == 4'hf) ? RESP_SLVERR : RESP_OKAY;
                if (rd_idx == STATUS_IDX)
                    s_axi_rdata <= {25'h0, status_word};
                else if (latch_writable(rd_idx))
                    s_axi_rdata <= {25'h0, latch_q[rd_idx[2:0]]};
                else
                    s_axi_rdata <= 32'h0;
            end
            else if (r_done)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    AST_PLL_MULT: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_pll_mult_q == ($past(rate_l) ? 5'h14 : 5'h0a))
        else $error("PLL multiplier does not follow rate select");

    AST_CLOCK_DOUBLE: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(rate_l) |=> tx_clock_double_q && tx_pll_mult_q == PLL_MULT_HALF)
        else $error("Clock output not doubled after rate select rose");

    AST_BOTH_EDGES: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_capture_both_edges_q == ($past(cksel_l) && $past(rate_l)))
        else $error("Both-edge capture does not match clock and rate selects");

    AST_SELFTEST: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_selftest_en_q != $past(latch_q[7][TX_SELFTEST_DISABLE_BIT]))
        else $error("Self-test enable not inverse of disable latch");

    AST_DRIVER_EN: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(drv1_l) |=> !tx_primary_driver_en_q)
        else $error("Primary driver stays enabled after latch cleared");

    AST_LOGIC_POWER: assert property (@(posedge aclk) disable iff (!aresetn)
        !tx_primary_driver_en_q && !tx_secondary_driver_en_q |-> !tx_logic_power_en_q)
        else $error("Channel logic powered with both drivers off");

    AST_RESET_DRIVERS: assert property (@(posedge aclk)
        !aresetn |=> !tx_primary_driver_en_q && !tx_secondary_driver_en_q)
        else $error("Driver enabled after reset sampled low");

    AST_RECENTER_SYNC: assert property (@(posedge aclk) disable iff (!aresetn)
        phase_buffer_recenter_q |-> $past(tx_clk_rise) && !$past(latch_q[7][0]))
        else $error("Recenter pulse without transmit clock edge and request");

    AST_RECENTER_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
        recenter_fire && !(latch_we && wr_idx_q == TX_CHANNEL_CTRL_IDX)
        |=> latch_q[7][PHASE_BUFFER_RECENTER_BIT] ##1 !phase_buffer_recenter_q)
        else $error("Recenter latch did not clear itself");

    AST_RESET_PATTERN: assert property (@(posedge aclk)
        aresetn && !$past(aresetn) |-> latch_q[5] == 7'h5f && latch_q[6] == 7'h56
        && latch_q[7] == 7'h59)
        else $error("Transmit latches not at reset pattern after reset");

    AST_RESERVED_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_commit && (wr_idx_q == INTERNAL_TEST_LOW_IDX || wr_idx_q == INTERNAL_TEST_HIGH_IDX)
        |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR && $stable(latch_q[3]))
        else $error("Reserved address write not refused");

endmodule

// file: hdl/cfg_latch_pkg.sv
package cfg_latch_pkg;

    // ****************************************
    // Latch map
    // ****************************************
    localparam int LATCH_COUNT = 8;
    localparam int LATCH_W = 7;
    localparam logic [3:0] RX_CLOCK_RATE_CFG_IDX = 4'h0;
    localparam logic [3:0] RX_DETECT_TRAINING_CFG_IDX = 4'h1;
    localparam logic [3:0] RX_CHANNEL_CTRL_IDX = 4'h2;
    localparam logic [3:0] INTERNAL_TEST_LOW_IDX = 4'h3;
    localparam logic [3:0] INTERNAL_TEST_HIGH_IDX = 4'h4;
    localparam logic [3:0] TX_STATIC_CFG_IDX = 4'h5;
    localparam logic [3:0] TX_CLOCKING_CFG_IDX = 4'h6;
    localparam logic [3:0] TX_CHANNEL_CTRL_IDX = 4'h7;
    localparam logic [3:0] STATUS_IDX = 4'h8;

    // ****************************************
    // Reset patterns
    // ****************************************
    localparam logic [6:0] RX_CLOCK_RATE_CFG_RST = 7'h5f;
    localparam logic [6:0] RX_DETECT_TRAINING_CFG_RST = 7'h56;
    localparam logic [6:0] RX_CHANNEL_CTRL_RST = 7'h59;
    localparam logic [6:0] INTERNAL_TEST_RST = 7'h00;
    localparam logic [6:0] TX_STATIC_CFG_RST = 7'h5f;
    localparam logic [6:0] TX_CLOCKING_CFG_RST = 7'h56;
    localparam logic [6:0] TX_CHANNEL_CTRL_RST = 7'h59;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int TX_PLL_RATE_SEL_BIT = 0;
    localparam int TX_INPUT_CLOCK_SEL_BIT = 1;
    localparam int PHASE_BUFFER_RECENTER_BIT = 0;
    localparam int TX_PRIMARY_DRIVER_EN_BIT = 1;
    localparam int TX_SECONDARY_DRIVER_EN_BIT = 2;
    localparam int TX_SELFTEST_DISABLE_BIT = 3;

    localparam int ST_PRIMARY_BIT = 0;
    localparam int ST_SECONDARY_BIT = 1;
    localparam int ST_LOGIC_POWER_BIT = 2;
    localparam int ST_RECENTER_PEND_BIT = 3;
    localparam int ST_INVALID_BIT = 4;
    localparam int ST_BOTH_EDGES_BIT = 5;
    localparam int ST_SPEED_BIT = 6;

    // ****************************************
    // Multipliers and responses
    // ****************************************
    localparam logic [4:0] PLL_MULT_FULL = 5'h0a;
    localparam logic [4:0] PLL_MULT_HALF = 5'h14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: hdl/cfg_sync2.sv
module cfg_sync2
#(
    parameter int WIDTH = 1
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ****************************************
    // Two-stage synchroniser
    // ****************************************
    logic [WIDTH-1:0] meta_q;

    generate
        if (WIDTH < 1)
        begin : g_chk
            $error("cfg_sync2 needs WIDTH of at least 1");
        end
    endgenerate

    // First stage feeds the second only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// file: verif/cfg_host_model.sv
module cfg_host_model
#(
    parameter int ADDR_W = 6
)
(
    input wire logic aclk,
    output logic [ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end

    // ****************************************
    // Write: address and data offered together
    // ****************************************
    task automatic write(input logic [ADDR_W-1:0] addr, input logic [31:0] data, input logic [3:0] strb,
        input int stall);
        bit aw_p;
        bit w_p;
        bit done;
        int n;
        @(posedge aclk);
        s_axi_awaddr <= addr;
        s_axi_wdata <= data;
        s_axi_wstrb <= strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= (stall == 0);
        aw_p = 1'b1;
        w_p = 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            done = s_axi_bready && s_axi_bvalid;
            if (aw_p && s_axi_awready)
            begin
                aw_p = 1'b0;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~addr;  // Released lines keep no stale value
            end
            if (w_p && s_axi_wready)
            begin
                w_p = 1'b0;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~data;
            end
            // Stall models a slow host
            if (n >= stall)
                s_axi_bready <= !done;
        end
        while (!done);
    endtask

    // ****************************************
    // Read
    // ****************************************
    task automatic read(input logic [ADDR_W-1:0] addr, input int stall);
        bit ar_p;
        bit done;
        int n;
        @(posedge aclk);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= (stall == 0);
        ar_p = 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            done = s_axi_rready && s_axi_rvalid;
            if (ar_p && s_axi_arready)
            begin
                ar_p = 1'b0;
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~addr;
            end
            if (n >= stall)
                s_axi_rready <= !done;
        end
        while (!done);
    endtask
endmodule

// file: verif/test_serdes_config_latch_bank.sv
module test_serdes_config_latch_bank
    import cfg_latch_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Signals
    // ****************************************
    logic aclk, aresetn, tx_speed_range_sel, tx_input_clock, spd;
    logic [5:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [4:0] tx_pll_mult_q;
    logic tx_clock_double_q, tx_capture_both_edges_q, tx_input_clock_sel_q, tx_selftest_en_q;
    logic tx_primary_driver_en_q, tx_secondary_driver_en_q, tx_logic_power_en_q;
    logic phase_buffer_recenter_q, config_invalid_q;
    wire logic [12:0] pins = {tx_pll_mult_q, tx_clock_double_q, tx_capture_both_edges_q, tx_input_clock_sel_q,
        tx_selftest_en_q, tx_primary_driver_en_q, tx_secondary_driver_en_q, tx_logic_power_en_q, config_invalid_q};
    localparam logic [6:0] RST [8] = '{RX_CLOCK_RATE_CFG_RST, RX_DETECT_TRAINING_CFG_RST, RX_CHANNEL_CTRL_RST,
        INTERNAL_TEST_RST, INTERNAL_TEST_RST, TX_STATIC_CFG_RST, TX_CLOCKING_CFG_RST, TX_CHANNEL_CTRL_RST};
    logic [6:0] lat [8];
    logic [33:0] exp_b [$];
    logic [33:0] exp_r [$];
    int compares = 0;
    int miscompares = 0;

    serdes_config_latch_bank #(.ADDR_W(6)) serdes_config_latch_bank_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .tx_speed_range_sel(tx_speed_range_sel), .tx_input_clock(tx_input_clock),
        .tx_pll_mult_q(tx_pll_mult_q), .tx_clock_double_q(tx_clock_double_q),
        .tx_capture_both_edges_q(tx_capture_both_edges_q), .tx_input_clock_sel_q(tx_input_clock_sel_q),
        .tx_selftest_en_q(tx_selftest_en_q), .tx_primary_driver_en_q(tx_primary_driver_en_q),
        .tx_secondary_driver_en_q(tx_secondary_driver_en_q), .tx_logic_power_en_q(tx_logic_power_en_q),
        .phase_buffer_recenter_q(phase_buffer_recenter_q), .config_invalid_q(config_invalid_q));

    cfg_host_model #(.ADDR_W(6)) cfg_host_model_i (.aclk(aclk), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));

    initial
        aclk = 1'b0;
    always #25 aclk = ~aclk;

    // ****************************************
    // Expectations and comparisons
    // ****************************************
    function automatic logic [12:0] pins_exp();
        logic [6:0] ck = lat[6];
        logic [6:0] ct = lat[7];
        return {ck[0] ? PLL_MULT_HALF : PLL_MULT_FULL, ck[0], ck[1] & ck[0], ck[1], ~ct[3], ct[1], ct[2],
            ct[1] | ct[2], ck[0] & ~spd};
    endfunction

    function automatic logic [31:0] st_exp();
        return {25'h0, spd, lat[6][1] & lat[6][0], lat[6][0] & ~spd, ~lat[7][0], lat[7][1] | lat[7][2],
            lat[7][2], lat[7][1]};
    endfunction

    task automatic cmp_bus(input string what, input logic [33:0] exp, input logic [33:0] got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_pin(input string what, input logic [12:0] exp, input logic [12:0] got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    always @(posedge aclk)
    begin
        if (s_axi_bvalid && s_axi_bready)
            cmp_bus("write response", exp_b.pop_front(), {s_axi_bresp, 32'h0});
        if (s_axi_rvalid && s_axi_rready)
            cmp_bus("read result", exp_r.pop_front(), {s_axi_rresp, s_axi_rdata});
    end

    task automatic wr(input logic [3:0] idx, input logic [6:0] d, input logic [1:0] resp);
        exp_b.push_back({resp, 32'h0});
        cfg_host_model_i.write({idx, 2'b00}, {25'h0, d}, 4'hf, $urandom_range(0, 2));
    endtask

    task automatic rd(input logic [3:0] idx, input logic [31:0] d, input logic [1:0] resp);
        exp_r.push_back({resp, d});
        cfg_host_model_i.read({idx, 2'b00}, $urandom_range(0, 2));
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask

    task automatic chk_all();
        for (int i = 0; i < 8; i++)
            rd(i[3:0], {25'h0, lat[i]}, RESP_OKAY);
        rd(STATUS_IDX, st_exp(), RESP_OKAY);
        settle(1);
        cmp_pin("outputs", pins_exp(), pins);
    endtask

    task automatic test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge aclk);
        $display("watchdog expired");
        miscompares++;
        test_done();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        logic [6:0] d;
        logic [3:0] i;
        int n;
        aresetn = 1'b0;
        spd = 1'b1;
        tx_speed_range_sel = 1'b1;
        tx_input_clock = 1'b0;
        lat = RST;
        void'($urandom(32'h790c));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        chk_all();
        $display("test reset values done");
        lat[5] = 7'h5d;
        wr(TX_STATIC_CFG_IDX, lat[5], RESP_OKAY);
        for (int m = 0; m < 4; m++)
        begin
            lat[6] = {4'b1010, 1'b0, m[1], m[0]};
            wr(TX_CLOCKING_CFG_IDX, lat[6], RESP_OKAY);
            settle(2);
            cmp_pin("clocking", pins_exp(), pins);
        end
        @(posedge aclk);
        tx_speed_range_sel <= 1'b0;
        spd = 1'b0;
        settle(4);
        cmp_pin("invalid combination", pins_exp(), pins);
        rd(STATUS_IDX, st_exp(), RESP_OKAY);
        @(posedge aclk);
        tx_speed_range_sel <= 1'b1;
        spd = 1'b1;
        $display("test clocking done");
        for (int k = 0; k < 8; k++)
        begin
            lat[7] = {3'b101, k[2], k[1], k[0], 1'b1};
            wr(TX_CHANNEL_CTRL_IDX, lat[7], RESP_OKAY);
            settle(2);
            cmp_pin("drivers", pins_exp(), pins);
            rd(STATUS_IDX, st_exp(), RESP_OKAY);
        end
        $display("test drivers done");
        lat[7][0] = 1'b0;
        wr(TX_CHANNEL_CTRL_IDX, lat[7], RESP_OKAY);
        rd(STATUS_IDX, st_exp(), RESP_OKAY);
        settle(1);
        cmp_pin("no recenter without clock", 13'h0, {12'h0, phase_buffer_recenter_q});
        @(posedge aclk);
        tx_input_clock <= 1'b1;
        n = 0;
        do
        begin
            settle(1);
            n++;
        end
        while (phase_buffer_recenter_q !== 1'b1 && n < 8);
        cmp_pin("recenter pulse", 13'h1, {12'h0, phase_buffer_recenter_q});
        settle(1);
        cmp_pin("recenter pulse end", 13'h0, {12'h0, phase_buffer_recenter_q});
        @(posedge aclk);
        tx_input_clock <= 1'b0;
        lat[7][0] = 1'b1;
        rd(TX_CHANNEL_CTRL_IDX, {25'h0, lat[7]}, RESP_OKAY);
        $display("test recenter done");
        wr(INTERNAL_TEST_LOW_IDX, 7'h2a, RESP_SLVERR);
        wr(INTERNAL_TEST_HIGH_IDX, 7'h55, RESP_SLVERR);
        wr(4'h9, 7'h7f, RESP_SLVERR);
        wr(STATUS_IDX, 7'h01, RESP_SLVERR);
        rd(4'h9, 32'h0, RESP_SLVERR);
        rd(INTERNAL_TEST_LOW_IDX, 32'h0, RESP_OKAY);
        exp_b.push_back({RESP_OKAY, 32'h0});
        cfg_host_model_i.write(6'h00, 32'h0000_0000, 4'h0, 0);
        rd(RX_CLOCK_RATE_CFG_IDX, {25'h0, lat[0]}, RESP_OKAY);
        $display("test refusals done");
        repeat (8)
        begin
            i = 4'($urandom_range(0, 3));
            i = (i == 4'h3) ? TX_STATIC_CFG_IDX : i;
            d = 7'($urandom);
            if (i == 4'h0)
                d = (d & 7'h19) | 7'h40;
            if (i == 4'h5)
                d[1] = 1'b0;
            if (i == 4'h2)
                d[4] = ~d[6];
            lat[i[2:0]] = d;
            wr(i, d, RESP_OKAY);
            rd(i, {25'h0, d}, RESP_OKAY);
        end
        $display("test random latches done");
        lat[7] = 7'h5f;
        wr(TX_CHANNEL_CTRL_IDX, lat[7], RESP_OKAY);
        settle(2);
        @(posedge aclk);
        aresetn <= 1'b0;
        lat = RST;
        settle(1);
        cmp_pin("outputs in reset", pins_exp(), pins);
        @(posedge aclk);
        aresetn <= 1'b1;
        chk_all();
        $display("test mid run reset done");
        test_done();
    end
endmodule
